// *** core/mci_defines.svh ***
// Constants shared by both ends of the modulator control link.
`ifndef MCI_DEFINES_SVH
`define MCI_DEFINES_SVH
// Clock rate
`define MCI_CLK_MHZ 25
// Pulse widths per range, in ns
`define MCI_WIDTH_SHORT_NS 75
`define MCI_WIDTH_MEDIUM_NS 300
`define MCI_WIDTH_LONG_NS 600
`define MCI_WIDTH_VLONG_NS 1050
`define MCI_WIDTH_LOWPWR_NS 1000
// Least times round up, longest times round down
`define MCI_NS_UP(ns) ((((ns) * `MCI_CLK_MHZ) + 999) / 1000)
`define MCI_NS_DN(ns) (((ns) * `MCI_CLK_MHZ) / 1000)
// Trigger low time, in ns
`define MCI_TRIG_LOW_NS 10000
`define MCI_TRIG_LOW_CYC `MCI_NS_DN(`MCI_TRIG_LOW_NS)
// Repetition period of the short range, in us; each longer range doubles it again
`define MCI_REP_SHORT_US 1000
`define MCI_REP_SHORT_CYC (`MCI_REP_SHORT_US * `MCI_CLK_MHZ)
// Speed confirmation square wave, in Hz
`define MCI_SPEED_HZ 590
`define MCI_SPEED_HALF_CYC ((`MCI_CLK_MHZ * 1000000) / (2 * `MCI_SPEED_HZ))
// Register byte offsets
`define MCI_OFS_CTRL 8'h00
`define MCI_OFS_STATUS 8'h04
`define MCI_OFS_IRQ_STAT 8'h08
`define MCI_OFS_IRQ_CLR 8'h0C
`define MCI_OFS_IRQ_EN 8'h10
// Control fields
`define MCI_CTRL_TXEN 0
`define MCI_CTRL_RANGE_LO 1
`define MCI_CTRL_MOTOR 3
`define MCI_CTRL_TRIG 4
`define MCI_CTRL_W 5
`define MCI_CTRL_RESET 5'h00
// Status fields
`define MCI_ST_HEATER 0
`define MCI_ST_SPEED 1
`define MCI_ST_BUILD3 2
`define MCI_ST_TRIG 3
// Interrupt fields
`define MCI_IRQ_TRIG 0
`define MCI_IRQ_HEATFAIL 1
`define MCI_IRQ_SPEED 2
`define MCI_IRQ_W 3
`endif

// *** core/mci_pkg.sv ***
// Types shared by both ends of the modulator control link.
package mci_pkg;
    // Coarse pulse range, code is {bit1, bit0}
    typedef enum logic [1:0] {
        MCI_RANGE_SHORT  = 2'h0,
        MCI_RANGE_MEDIUM = 2'h1,
        MCI_RANGE_LONG   = 2'h2,
        MCI_RANGE_VLONG  = 2'h3
    } mci_range_t;
    // Modulator pulse states
    typedef enum logic [1:0] {
        MCI_DEV_IDLE = 2'h1,
        MCI_DEV_FIRE = 2'h2
    } mci_dev_state_t;
    // Controller trigger states
    typedef enum logic [1:0] {
        MCI_TRG_IDLE = 2'h1,
        MCI_TRG_RUN  = 2'h2
    } mci_trg_state_t;
endpackage : mci_pkg

// *** core/mci_link_if.sv ***
// Control and status wires between controller and modulator.
`timescale 1ns/10ps
interface mci_link_if;
    logic transmitEnable;  // Pulses allowed when high
    logic widthRangeBit0;  // Range code, low bit
    logic widthRangeBit1;  // Range code, high bit
    logic transmitTriggerN; // Low-going trigger
    logic motorEnN;        // Motor runs while low
    logic heaterOk;        // Heater health
    logic speedOut;        // Modulator drive of speed line
    logic speedOeN;        // Low while modulator drives
    logic speedLine;       // Resolved level, pulled high
    // Pull-up when nobody drives the speed line
    assign speedLine = speedOeN ? 1'b1 : speedOut;
    modport controller (
        output transmitEnable, widthRangeBit0, widthRangeBit1,
        output transmitTriggerN, motorEnN,
        input  heaterOk, speedLine
    );
    modport modulator (
        input  transmitEnable, widthRangeBit0, widthRangeBit1,
        input  transmitTriggerN, motorEnN,
        output heaterOk, speedOut, speedOeN
    );
endinterface : mci_link_if

// *** core/mci_edge_sync.sv ***
// Two-stage synchroniser with rise and fall detection.
`timescale 1ns/10ps
module mci_edge_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic din,
    input  wire logic resetLevel,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;  // First stage, read only by the second
    logic sync_reg;  // Second stage
    logic last_reg;  // Previous synced level
    // Resting level comes up as one; inputs idling low show a fall
    // after reset, so callers gate edges with their own state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    // Edges compare second and third stages only
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg & ~resetLevel;
    assign fall  = ~sync_reg & last_reg;
endmodule : mci_edge_sync

// *** core/mci_modulator_end.sv ***
// Modulator end: pulse generation, heater status, motor and speed line.
//
// Notes on behaviour
// - Transmit enable low suppresses every pulse
// - Range code short, medium, long, very long
// - Pulse starts at trigger rising edge
// - Controller scales repetition rate with range
// - Pulse 75 ns to 1.05 us, capped
// - Heater health output follows heater sense
// - Motor runs while motor enable low
// - Square wave near 590 Hz at speed
// - Motor off holds speed line low
`timescale 1ns/10ps
`include "mci_defines.svh"
module mci_modulator_end import mci_pkg::*; #(
    parameter int SPEED_HALF_CYC = `MCI_SPEED_HALF_CYC,
    parameter bit LOW_POWER_UNIT = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          reset_n,
    mci_link_if.modulator      link,
    input  wire logic          heaterSense,
    input  wire logic          motorAtSpeed,
    output logic               modPulse,
    output logic               motorRun
);
    // Counter widths
    localparam int CNT_W = 6;
    localparam int SPD_W = $clog2(SPEED_HALF_CYC + 1);
    // Cycle counts per range
    localparam logic [CNT_W-1:0] CYC_SHORT  = CNT_W'(`MCI_NS_UP(`MCI_WIDTH_SHORT_NS));
    localparam logic [CNT_W-1:0] CYC_MEDIUM = CNT_W'(`MCI_NS_DN(`MCI_WIDTH_MEDIUM_NS));
    localparam logic [CNT_W-1:0] CYC_LONG   = CNT_W'(`MCI_NS_DN(`MCI_WIDTH_LONG_NS));
    localparam logic [CNT_W-1:0] CYC_VLONG  = CNT_W'(`MCI_NS_DN(`MCI_WIDTH_VLONG_NS));
    localparam logic [CNT_W-1:0] CYC_LOWPWR = CNT_W'(`MCI_NS_DN(`MCI_WIDTH_LOWPWR_NS));
    // The low-power unit may never exceed its shorter ceiling
    localparam logic [CNT_W-1:0] CYC_CAP    = LOW_POWER_UNIT ? CYC_LOWPWR : CYC_VLONG;
    localparam logic [SPD_W-1:0] SPD_LAST   = SPD_W'(SPEED_HALF_CYC - 1);

    // Refuse values the counters cannot hold
    if (SPEED_HALF_CYC < 1) begin : gBadSpeed
        $error("SPEED_HALF_CYC must be at least one");
    end
    if (`MCI_NS_DN(`MCI_WIDTH_VLONG_NS) >= (1 << CNT_W)) begin : gBadWidth
        $error("Pulse counter too narrow for the longest range");
    end

    // Width in cycles for a range code, clamped to the unit's ceiling
    function automatic logic [CNT_W-1:0] widthCycles(input mci_range_t code);
        logic [CNT_W-1:0] raw;
        raw = CYC_SHORT;
        case (code)
            MCI_RANGE_SHORT:  raw = CYC_SHORT;
            MCI_RANGE_MEDIUM: raw = CYC_MEDIUM;
            MCI_RANGE_LONG:   raw = CYC_LONG;
            MCI_RANGE_VLONG:  raw = CYC_VLONG;
            default:          raw = CYC_SHORT;
        endcase
        return (raw > CYC_CAP) ? CYC_CAP : raw;
    endfunction : widthCycles

    // State and counters
    mci_dev_state_t    state_reg;     // Pulse state
    mci_dev_state_t    state_next;
    logic [CNT_W-1:0]  width_reg;     // Cycles left in pulse
    logic [CNT_W-1:0]  width_next;
    logic              pulse_reg;     // Modulator drive
    logic              pulse_next;
    logic              heater_reg;    // Heater health to link
    logic              motor_reg;     // Motor switch
    logic [SPD_W-1:0]  spd_reg;       // Half-period divider
    logic [SPD_W-1:0]  spd_next;
    logic              spdOut_reg;    // Speed line level
    logic              spdOut_next;
    logic              spdOeN_reg;    // Speed line enable, low drives
    logic              armed_reg;     // Trigger seen high since reset

    // Decoded link inputs
    wire               trigLevel;     // Synced trigger level
    wire               trigRise;      // One-cycle rising edge
    wire mci_range_t   rangeCode = mci_range_t'({link.widthRangeBit1, link.widthRangeBit0});
    wire               txEnabled = link.transmitEnable;
    wire               fireStart;     // Accepted trigger
    wire               pulseDone;     // Last cycle of a pulse
    wire               spinning;      // Motor running at speed
    wire               spdWrap;       // Divider half-period end

    mci_edge_sync u_trig_sync (
        .clk        (clk),
        .reset_n    (reset_n),
        .din        (link.transmitTriggerN),
        .resetLevel (~armed_reg),
        .level      (trigLevel),
        .rise       (trigRise),
        .fall       ()
    );

    // The edge detector is armed once the synced trigger level reads high; its reset value of one
    // does so in the first cycle, so a line held low through reset still fires on release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
        end else if (trigLevel) begin
            armed_reg <= 1'b1;
        end
    end

    assign fireStart = trigRise & txEnabled & (state_reg == MCI_DEV_IDLE);
    assign pulseDone = (width_reg == CNT_W'(1));

    // Pulse state machine
    always_comb begin
        state_next = state_reg;
        width_next = width_reg;
        pulse_next = 1'b0;
        case (state_reg)
            MCI_DEV_IDLE: begin
                if (fireStart) begin
                    // Range is sampled once, at the start of the pulse
                    state_next = MCI_DEV_FIRE;
                    width_next = widthCycles(rangeCode);
                    pulse_next = 1'b1;
                end
            end
            MCI_DEV_FIRE: begin
                if (!txEnabled || pulseDone) begin
                    state_next = MCI_DEV_IDLE;
                    width_next = '0;
                end else begin
                    width_next = width_reg - CNT_W'(1);
                    pulse_next = 1'b1;
                end
            end
            default: begin
                state_next = MCI_DEV_IDLE;
                width_next = '0;
            end
        endcase
    end

    // Pulse registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= MCI_DEV_IDLE;
            width_reg <= '0;
            pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            width_reg <= width_next;
            pulse_reg <= pulse_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            heater_reg <= 1'b0;
            motor_reg  <= 1'b0;
        end else begin
            heater_reg <= heaterSense;
            motor_reg  <= ~link.motorEnN;
        end
    end

    // Speed divider runs only once the antenna reports full speed
    assign spinning = motor_reg & motorAtSpeed;
    assign spdWrap  = (spd_reg == SPD_LAST);

    // Divider and line level
    always_comb begin
        spd_next    = '0;
        spdOut_next = 1'b0;
        if (spinning) begin
            if (spdWrap) begin
                spdOut_next = ~spdOut_reg;
            end else begin
                spd_next    = spd_reg + SPD_W'(1);
                spdOut_next = spdOut_reg;
            end
        end else begin
            spdOut_next = 1'b0;
        end
    end

    // Speed line registers; the line is released only during reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spd_reg    <= '0;
            spdOut_reg <= 1'b0;
            spdOeN_reg <= 1'b1;
        end else begin
            spd_reg    <= spd_next;
            spdOut_reg <= spdOut_next;
            spdOeN_reg <= 1'b0;
        end
    end

    // Outputs come straight from registers
    assign modPulse      = pulse_reg;
    assign motorRun      = motor_reg;
    assign link.heaterOk = heater_reg;
    assign link.speedOut = spdOut_reg;
    assign link.speedOeN = spdOeN_reg;
endmodule : mci_modulator_end

// *** core/mci_controller_end.sv ***
// Controller end: AXI4-Lite registers, trigger generation and status.
`timescale 1ns/10ps
`include "mci_defines.svh"
module mci_controller_end import mci_pkg::*; #(
    parameter int REP_SHORT_CYC  = `MCI_REP_SHORT_CYC,
    parameter int SPEED_LOSS_CYC = 4 * `MCI_SPEED_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    mci_link_if.controller   link,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             irq
);
    localparam int REP_W = $clog2(REP_SHORT_CYC * 8 + 1);
    localparam int LOS_W = $clog2(SPEED_LOSS_CYC + 1);
    localparam logic [REP_W-1:0] LOW_CYC = REP_W'(`MCI_TRIG_LOW_CYC);
    // Refuse a period that cannot contain the trigger low time
    if (REP_SHORT_CYC <= `MCI_TRIG_LOW_CYC || SPEED_LOSS_CYC < 1) begin : gBad
        $error("Repetition or speed timeout too short");
    end

    // Registers
    logic [`MCI_CTRL_W-1:0] ctrl_reg;      // Software orders
    logic [`MCI_IRQ_W-1:0]  irqStat_reg;   // Sticky events
    logic [`MCI_IRQ_W-1:0]  irqEn_reg;     // Event enables
    logic [3:0]             status_reg;    // Live status
    logic                   irq_reg;
    // Bus state
    logic awFull_reg, wFull_reg, awRdy_reg, wRdy_reg, bvalid_reg, arRdy_reg, rvalid_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    // Trigger generator
    mci_trg_state_t   trg_reg;
    logic [REP_W-1:0] cnt_reg, period_reg;
    logic [1:0]       range_reg;          // Range driven to the link
    logic             trigN_reg;
    logic [LOS_W-1:0] loss_reg;           // Cycles since last speed edge
    logic             speedOk_reg, heaterLast_reg;

    // Write channel bookkeeping; address and data taken in either order
    wire awTake  = s_awvalid & awRdy_reg;
    wire wTake   = s_wvalid & wRdy_reg;
    wire awHave  = awFull_reg | awTake;
    wire wHave   = wFull_reg | wTake;
    wire doWrite = awHave & wHave;
    wire awFullN = awHave & ~doWrite;
    wire wFullN  = wHave & ~doWrite;
    wire bvalidN = doWrite | (bvalid_reg & ~s_bready);
    wire arTake  = s_arvalid & arRdy_reg;
    wire rvalidN = arTake | (rvalid_reg & ~s_rready);
    wire [7:0]  wrAddr = awFull_reg ? awAddr_reg : s_awaddr;
    wire [31:0] wrData = wFull_reg ? wData_reg : s_wdata;
    wire        wrLane = wFull_reg ? wStrb_reg[0] : s_wstrb[0];
    // Address decode
    wire wrCtrl = doWrite && wrLane && (wrAddr == `MCI_OFS_CTRL);
    wire wrClr  = doWrite && wrLane && (wrAddr == `MCI_OFS_IRQ_CLR);
    wire wrEn   = doWrite && wrLane && (wrAddr == `MCI_OFS_IRQ_EN);
    wire wrMap  = (wrAddr == `MCI_OFS_CTRL) || (wrAddr == `MCI_OFS_STATUS) ||
                  (wrAddr == `MCI_OFS_IRQ_STAT) || (wrAddr == `MCI_OFS_IRQ_CLR) ||
                  (wrAddr == `MCI_OFS_IRQ_EN);
    wire [31:0] rdMux = (s_araddr == `MCI_OFS_CTRL)     ? 32'(ctrl_reg) :
                        (s_araddr == `MCI_OFS_STATUS)   ? 32'(status_reg) :
                        (s_araddr == `MCI_OFS_IRQ_STAT) ? 32'(irqStat_reg) :
                        (s_araddr == `MCI_OFS_IRQ_EN)   ? 32'(irqEn_reg) : 32'h0000_0000;
    wire rdMap  = (s_araddr == `MCI_OFS_CTRL) || (s_araddr == `MCI_OFS_STATUS) ||
                  (s_araddr == `MCI_OFS_IRQ_STAT) || (s_araddr == `MCI_OFS_IRQ_CLR) ||
                  (s_araddr == `MCI_OFS_IRQ_EN);

    // Bus slave registers; readies are precomputed so they leave flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {awFull_reg, wFull_reg, bvalid_reg, rvalid_reg} <= 4'h0;
            {awRdy_reg, wRdy_reg, arRdy_reg} <= 3'h7;
            awAddr_reg <= 8'h00;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            bresp_reg  <= 2'h0;
            rresp_reg  <= 2'h0;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            awFull_reg <= awFullN;
            wFull_reg  <= wFullN;
            bvalid_reg <= bvalidN;
            rvalid_reg <= rvalidN;
            awRdy_reg  <= ~awFullN & ~bvalidN;
            wRdy_reg   <= ~wFullN & ~bvalidN;
            arRdy_reg  <= ~rvalidN;
            if (awTake) awAddr_reg <= s_awaddr;
            if (wTake) begin
                wData_reg <= s_wdata;
                wStrb_reg <= s_wstrb;
            end
            // Unmapped addresses answer SLVERR
            if (doWrite) bresp_reg <= wrMap ? 2'h0 : 2'h2;
            if (arTake) begin
                rdata_reg <= rdMux;
                rresp_reg <= rdMap ? 2'h0 : 2'h2;
            end
        end
    end

    // Speed line edges and level
    wire spdRise, spdFall, spdLevel;
    mci_edge_sync u_spd_sync (
        .clk        (clk),
        .reset_n    (reset_n),
        .din        (link.speedLine),
        .resetLevel (1'b0),
        .level      (spdLevel),
        .rise       (spdRise),
        .fall       (spdFall)
    );
    wire motorOn  = ctrl_reg[`MCI_CTRL_MOTOR];
    wire spdEdge  = (spdRise | spdFall) & motorOn;
    wire spdLost  = (loss_reg == LOS_W'(SPEED_LOSS_CYC - 1)) || !motorOn;
    wire [1:0] rangeSel = ctrl_reg[`MCI_CTRL_RANGE_LO +: 2];
    wire [REP_W-1:0] periodSel = REP_W'(REP_SHORT_CYC) << rangeSel;
    wire trgIdle  = (trg_reg == MCI_TRG_IDLE);
    wire wrap     = (cnt_reg == period_reg - REP_W'(1));
    wire lowEnd   = (cnt_reg == LOW_CYC - REP_W'(1)) & ~trgIdle;
    wire trgStart = ctrl_reg[`MCI_CTRL_TRIG] & (trgIdle | wrap);
    // Events: trigger released, heater failed, speed confirmed
    wire [`MCI_IRQ_W-1:0] events = {spdEdge & ~speedOk_reg, heaterLast_reg & ~link.heaterOk, lowEnd};
    wire [`MCI_IRQ_W-1:0] clrMask = wrClr ? wrData[`MCI_IRQ_W-1:0] : '0;
    wire [`MCI_IRQ_W-1:0] statN = (irqStat_reg & ~clrMask) | events;
    wire [`MCI_IRQ_W-1:0] enN = wrEn ? wrData[`MCI_IRQ_W-1:0] : irqEn_reg;

    // Software registers; an event in the clearing cycle survives
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg    <= `MCI_CTRL_RESET;
            irqStat_reg <= '0;
            irqEn_reg   <= '0;
            irq_reg     <= 1'b0;
        end else begin
            if (wrCtrl) ctrl_reg <= wrData[`MCI_CTRL_W-1:0];
            irqStat_reg <= statN;
            irqEn_reg   <= enN;
            irq_reg     <= |(statN & enN);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trg_reg    <= MCI_TRG_IDLE;
            cnt_reg    <= '0;
            period_reg <= REP_W'(REP_SHORT_CYC);
            range_reg  <= 2'h0;
            trigN_reg  <= 1'b1;
        end else if (trgStart) begin
            // Range changes only between triggers, never mid-pulse
            trg_reg    <= MCI_TRG_RUN;
            cnt_reg    <= '0;
            period_reg <= periodSel;
            range_reg  <= rangeSel;
            trigN_reg  <= 1'b0;
        end else if (!trgIdle) begin
            cnt_reg   <= cnt_reg + REP_W'(1);
            if (lowEnd) trigN_reg <= 1'b1;
            // Stopping waits for the trigger to end high
            if (wrap || (!ctrl_reg[`MCI_CTRL_TRIG] && trigN_reg)) trg_reg <= MCI_TRG_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            loss_reg       <= '0;
            speedOk_reg    <= 1'b0;
            heaterLast_reg <= 1'b0;
            status_reg     <= 4'h0;
        end else begin
            loss_reg       <= (spdEdge || spdLost) ? '0 : loss_reg + LOS_W'(1);
            speedOk_reg    <= spdEdge | (speedOk_reg & ~spdLost);
            heaterLast_reg <= link.heaterOk;
            status_reg[`MCI_ST_HEATER] <= link.heaterOk;
            status_reg[`MCI_ST_SPEED]  <= speedOk_reg;
            status_reg[`MCI_ST_BUILD3] <= ~motorOn & ~spdLevel;
            status_reg[`MCI_ST_TRIG]   <= ~trgIdle;
        end
    end

    // Outputs from registers
    assign link.transmitEnable   = ctrl_reg[`MCI_CTRL_TXEN];
    assign link.widthRangeBit0   = range_reg[0];
    assign link.widthRangeBit1   = range_reg[1];
    assign link.transmitTriggerN = trigN_reg;
    assign link.motorEnN         = ~ctrl_reg[`MCI_CTRL_MOTOR];
    assign s_awready = awRdy_reg;
    assign s_wready  = wRdy_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;
    assign s_arready = arRdy_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rdata   = rdata_reg;
    assign s_rresp   = rresp_reg;
    assign irq       = irq_reg;
endmodule : mci_controller_end

// *** verif/mci_link_properties.sv ***
// Link assertions for the modulator control interface.
`timescale 1ns/10ps
module mci_link_properties #(parameter int SPEED_HALF_CYC = 8) (
    input wire logic clk, reset_n, transmitEnable, widthRangeBit0, widthRangeBit1, transmitTriggerN,
    input wire logic motorEnN, heaterOk, speedOut, speedLine, modPulse, motorRun, heaterSense, motorAtSpeed
);
    localparam int TOG_MAX = SPEED_HALF_CYC + 2; // Slack for the start-up cycle
    logic [8:0] lowCnt; // Trigger low cycles
    logic [5:0] widCnt; // Pulse high cycles
    logic [5:0] widExp; // Width owed to the range
    assign widExp = widthRangeBit1 ? (widthRangeBit0 ? 6'h1A : 6'h0F) : (widthRangeBit0 ? 6'h07 : 6'h02);
    // Counters restart when their phase ends: trigger back high, pulse dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt <= 9'h000;
            widCnt <= 6'h00;
        end else begin
            lowCnt <= transmitTriggerN ? 9'h000 : lowCnt + 9'h001;
            widCnt <= modPulse ? widCnt + 6'h01 : 6'h00;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence trigRise; $rose(transmitTriggerN) && transmitEnable; endsequence
    sequence motorOff; motorEnN [*4]; endsequence
    AST_TX_OFF: assert property (!transmitEnable |=> !modPulse)
        else $error("pulse while disabled");
    AST_START: assert property (trigRise |-> ##[3:5] $rose(modPulse))
        else $error("no pulse after trigger");
    AST_WIDTH: assert property ($fell(modPulse) && transmitEnable |-> widCnt == widExp)
        else $error("pulse width wrong");
    AST_TRIG_LOW: assert property ($rose(transmitTriggerN) |-> lowCnt == 9'h0FA)
        else $error("trigger low time wrong");
    AST_HEATER: assert property ($past(reset_n) |-> heaterOk == $past(heaterSense))
        else $error("heater flag wrong");
    AST_MOTOR: assert property ($past(reset_n) |-> motorRun == !$past(motorEnN))
        else $error("motor state wrong");
    AST_SPEED: assert property ((motorRun && motorAtSpeed) [*2] |-> ##[0:TOG_MAX] $changed(speedOut))
        else $error("speed line idle");
    AST_BUILD_ID: assert property (motorOff |-> !speedLine)
        else $error("build line not low");
endmodule : mci_link_properties

// *** verif/test_modulator_control_interface.sv ***
// Bench for both ends of the modulator control link.
`timescale 1ns/10ps
module test_modulator_control_interface;
    logic clk, reset_n, heaterSense, irq, modPulse, motorRun, motorAtSpeed;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rdV;
    logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rrV;
    logic [3:0] s_wstrb; // Write lanes, only lane 0 matters
    logic [5:0] widTab [4] = '{6'h02, 6'h07, 6'h0F, 6'h1A}; // Pulse cycles per range
    int errors = 0, samples_checked = 0, cyc = 0, n, t0;
    mci_link_if link ();
    mci_controller_end #(.REP_SHORT_CYC(300), .SPEED_LOSS_CYC(40)) mci_controller_end_i (.clk, .reset_n, .link,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .irq);
    mci_modulator_end #(.SPEED_HALF_CYC(8)) mci_modulator_end_i (.clk, .reset_n, .link, .heaterSense,
        .motorAtSpeed, .modPulse, .motorRun);
    mci_link_properties #(.SPEED_HALF_CYC(8)) mci_link_properties_i (.clk, .reset_n, .modPulse, .motorRun,
        .heaterSense, .motorAtSpeed, .transmitEnable(link.transmitEnable), .motorEnN(link.motorEnN),
        .widthRangeBit0(link.widthRangeBit0), .widthRangeBit1(link.widthRangeBit1), .heaterOk(link.heaterOk),
        .transmitTriggerN(link.transmitTriggerN), .speedOut(link.speedOut), .speedLine(link.speedLine));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // Write holds each half until taken, bready until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        rrV = s_bresp;
        s_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        {rdV, rrV} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
    endtask : rd
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // Hang guard, well above the longest pulse period
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            conclude;
        end
    end
    initial begin
        {clk, reset_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
        {heaterSense, motorAtSpeed, s_wstrb} = 6'h2F;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // Status trails the link by up to four cycles after reset
        repeat (4) @(posedge clk);
        rd(8'h04);
        chk(rdV, 32'h5);
        chk(rrV, 2'h0);
        rd(8'h20);
        chk(rrV, 2'h2);
        wr(8'h24, 32'h0);
        chk(rrV, 2'h2);
        for (int r = 0; r < 4; r++) begin
            wr(8'h00, 32'h11 | (r << 1));
            do @(posedge clk); while (modPulse !== 1'b1);
            if (r > 0) chk(cyc - t0, 300 << (r - 1));
            t0 = cyc;
            for (n = 0; modPulse === 1'b1; n++) @(posedge clk);
            chk(n, widTab[r]);
        end
        $display("ranges done");
        wr(8'h00, 32'h0);
        rd(8'h08);
        chk(rdV, 32'h1);
        chk(irq, 1'b0);
        wr(8'h10, 32'h1);
        chk(rrV, 2'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(8'h0C, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        $display("interrupt done");
        s_wstrb <= 4'hE;
        wr(8'h00, 32'h1F);
        s_wstrb <= 4'hF;
        rd(8'h00);
        chk(rdV, 32'h0);
        wr(8'h00, 32'h10);
        n = 0;
        repeat (700) @(posedge clk) if (modPulse !== 1'b0) n++;
        chk(n, 0);
        wr(8'h00, 32'h8);
        repeat (40) @(posedge clk);
        chk(motorRun, 1'b1);
        rd(8'h04);
        chk(rdV[2:0], 3'h1);
        motorAtSpeed <= 1'b1;
        repeat (40) @(posedge clk);
        rd(8'h04);
        chk(rdV[2:0], 3'h3);
        heaterSense <= 1'b0;
        wr(8'h00, 32'h0);
        repeat (8) @(posedge clk);
        chk(link.speedLine, 1'b0);
        chk(link.heaterOk, 1'b0);
        rd(8'h04);
        chk(rdV[2:0], 3'h4);
        rd(8'h08);
        chk(rdV, 32'h7);
        chk(irq, 1'b1);
        $display("motor and heater done");
        conclude;
    end
endmodule : test_modulator_control_interface
